// ---- logic/csb_consts.svh ----
// Purpose: Shared constants of the compare-skip and BCD adjust unit
// Assumes: Included by its bare name from the adjust unit and core files
// Notes: Numbers live here only; types live in csb_pkg
//
// Functional notes
// RULE1: Decode skip-if-greater from 0110 010 pattern
// RULE2: Decode skip-if-less from 0110 000 pattern
// RULE3: Compare by unsigned subtract; flags stay untouched
// RULE4: Greater variant skips only when byte exceeds
// RULE5: Less variant skips only when byte below
// RULE6: Skipped word becomes quiet no-operation cycle
// RULE7: One word; one cycle, two if skip
// RULE8: Skipping two-word instruction costs three cycles
// RULE9: Access bit zero selects fixed access bank
// RULE10: Access bit one takes bank select register
// RULE11: Low nibble plus six if above nine/digit carry
// RULE12: Adjust sum of packed BCD into BCD
// RULE13: High nibble plus six if above nine/carry
// RULE14: Decimal adjust opcode has only bits 2:0 set
`ifndef CSB_CONSTS_SVH
`define CSB_CONSTS_SVH

// Quarter phases of one instruction cycle
`define CSB_Q1 2'h0
`define CSB_Q2 2'h1
`define CSB_Q3 2'h2
`define CSB_Q4 2'h3
// Opcode decode masks and patterns
`define CSB_CMP_MASK 16'hfe00
`define CSB_OP_CMP_GT 16'h6400
`define CSB_OP_CMP_LT 16'h6000
`define CSB_OP_DAW 16'h0007
// Opcode field positions
`define CSB_ABIT 8
`define CSB_ACC_SPLIT 7
// Decimal adjust figures
`define CSB_BCD_LIMIT 4'h9
`define CSB_BCD_ADJ 4'h6
// Instruction cycle length in clocks
`define CSB_CLK_PER_CYC 4

`endif

// ---- logic/csb_pkg.sv ----
// Purpose: Types of the compare-skip and BCD adjust unit
// Assumes: Used with full package names, never imported
// Notes: Sequencer states are Gray coded along the skip path except from CSB_SKIP2 back to CSB_EXEC
package csb_pkg;

    // Instruction sequencer states
    typedef enum logic [1:0] {
        CSB_EXEC  = 2'h0, // Normal execution
        CSB_SKIP1 = 2'h1, // First discarded cycle
        CSB_SKIP2 = 2'h3  // Second word of a skipped pair
    } csb_state_type;

    // Decoded instruction kind
    typedef enum logic [1:0] {
        CSB_OP_NONE = 2'h0, // Not handled here
        CSB_OP_GT   = 2'h1, // Compare, skip if greater
        CSB_OP_LT   = 2'h2, // Compare, skip if less
        CSB_OP_DAW  = 2'h3  // Decimal adjust working
    } csb_op_type;

endpackage

// ---- logic/csb_bcd_if.sv ----
// Purpose: Carries the decimal adjust operands and result
// Assumes: Both ends sit on the same clock
// Notes: Purely combinational bundle
`timescale 1ns/1ps
interface csb_bcd_if;
    logic [7:0] working_register; // Working register value
    logic dc; // Digit carry flag in
    logic carry_in; // Carry flag in
    logic [7:0] result; // Adjusted value
    logic carry_out; // Carry flag out

    // Adjust unit side
    modport calc (input working_register, dc, carry_in, output result, carry_out);
    // Sequencer side
    modport user (output working_register, dc, carry_in, input result, carry_out);
endinterface

// ---- logic/csb_bcd_adjust.sv ----
// Purpose: Nibble correction of the decimal adjust instruction
// Assumes: Operands stable during the process quarter
// Notes: Low nibble first so its carry ripples upward
`timescale 1ns/1ps
`include "csb_consts.svh"
module csb_bcd_adjust (
    // Operands and result
    csb_bcd_if.calc port
);
    logic [8:0] stage [0:2]; // Value after each nibble step
    logic [1:0] fix; // Nibble needs plus six

    assign stage[0] = {1'b0, port.working_register};

    // One correction step per nibble, low nibble first
    for (genvar i = 0; i < 2; i++) begin : g_nib
        logic [3:0] nib; // Nibble under test
        logic flag; // Its carry condition
        assign nib = stage[i][4*i +: 4];
        // Low step looks at digit carry, high at carry
        assign flag = (i == 0) ? port.dc
                               : (port.carry_in | stage[i][8]);
        assign fix[i] = (nib > `CSB_BCD_LIMIT) | flag; // see RULE11
        assign stage[i+1] = stage[i] + (fix[i] ?
            (9'(`CSB_BCD_ADJ) << (4*i)) : 9'h000); // see RULE13
    end

    // Result and carry; an earlier carry is never cleared
    assign port.result = stage[2][7:0]; // see RULE12
    assign port.carry_out = port.carry_in | stage[2][8]; // see RULE13

endmodule // csb_bcd_adjust

// ---- logic/csb_core.sv ----
// Purpose: Executes compare-skip and decimal adjust instructions
// Assumes: All inputs come from core logic on i_mclk
// Notes: Four clocks form one instruction cycle, Q1 to Q4
`timescale 1ns/1ps
`include "csb_consts.svh"
module csb_core #(
    parameter int BANK_W = 4 // Data memory bank number width
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_resetn,
    // Instruction stream, sampled in Q1 and Q3
    input wire logic [15:0] i_opcode,
    input wire logic i_next_two_word,
    // Core register view
    input wire logic [7:0] i_working_register,
    input wire logic [BANK_W-1:0] i_bank_select_register,
    input wire logic i_carry,
    input wire logic i_digit_carry_flag,
    // Data memory read port
    input wire logic [7:0] i_mem_rdata,
    output logic [BANK_W+7:0] o_mem_addr,
    output logic o_mem_rd,
    // Write-back of working register and carry
    output logic [7:0] o_working_register_data,
    output logic o_working_register_we,
    output logic o_carry,
    output logic o_carry_we,
    // Sequencing status
    output logic [1:0] o_q_phase,
    output logic o_skip_nop,
    output logic o_skip_taken
);

    // Decode an opcode into an instruction kind
    function automatic csb_pkg::csb_op_type decode_op(
        input logic [15:0] op
    );
        csb_pkg::csb_op_type kind;
        kind = csb_pkg::CSB_OP_NONE;
        if ((op & `CSB_CMP_MASK) == `CSB_OP_CMP_GT) begin
            kind = csb_pkg::CSB_OP_GT; // see RULE1
        end else if ((op & `CSB_CMP_MASK) == `CSB_OP_CMP_LT) begin
            kind = csb_pkg::CSB_OP_LT; // see RULE2
        end else if (op == `CSB_OP_DAW) begin
            kind = csb_pkg::CSB_OP_DAW; // see RULE14
        end
        return kind;
    endfunction

    // True for either compare-skip kind
    function automatic logic is_cmp(input csb_pkg::csb_op_type k);
        return (k == csb_pkg::CSB_OP_GT) || (k == csb_pkg::CSB_OP_LT);
    endfunction

    // Bank of the operand from the access bit
    function automatic logic [BANK_W-1:0] bank_of(
        input logic abit,
        input logic [7:0] f,
        input logic [BANK_W-1:0] bank_select_register
    );
        logic [BANK_W-1:0] bank;
        if (abit) begin
            bank = bank_select_register; // see RULE10
        end else if (f[`CSB_ACC_SPLIT]) begin
            bank = {BANK_W{1'b1}}; // see RULE9
        end else begin
            bank = '0; // see RULE9
        end
        return bank;
    endfunction

    // Sequencer state
    logic [1:0] q_ff, nxt_q; // Quarter phase
    csb_pkg::csb_state_type state_ff, nxt_state; // Skip sequencer
    csb_pkg::csb_op_type kind_ff, nxt_kind; // Instruction in flight
    logic [7:0] f_ff, nxt_f; // File address field
    logic abit_ff, nxt_abit; // Access bit
    logic skip_ff, nxt_skip; // Compare says skip
    logic two_ff, nxt_two; // Next word is a two-word instruction
    logic nop_ff, nxt_nop; // Current cycle is discarded
    logic taken_ff, nxt_taken; // Skip entered this clock

    // Datapath state
    logic [BANK_W+7:0] addr_ff, nxt_addr; // Operand address
    logic rd_ff, nxt_rd; // Read strobe
    logic [7:0] wdata_ff, nxt_wdata; // Write-back value
    logic we_ff, nxt_we; // Write-back strobe
    logic carry_ff, nxt_carry; // Carry value
    logic cwe_ff, nxt_cwe; // Carry strobe

    // Compare result
    logic [8:0] diff; // Unsigned difference, kept for borrow and zero test
    logic cmp_hit; // Skip condition met

    csb_bcd_if bif ();

    // Decimal adjust operands come straight from the core
    assign bif.working_register = i_working_register;
    assign bif.dc = i_digit_carry_flag;
    assign bif.carry_in = i_carry;

    csb_bcd_adjust u_bcd (
        .port (bif.calc)
    );

    // Subtract and test; the difference is never written back
    always_comb begin
        diff = {1'b0, i_mem_rdata} - {1'b0, i_working_register}; // see RULE3
        case (kind_ff)
            csb_pkg::CSB_OP_GT: begin
                // No borrow and not zero means strictly greater
                cmp_hit = !diff[8] && (diff[7:0] != 8'h00); // see RULE4
            end
            csb_pkg::CSB_OP_LT: begin
                cmp_hit = diff[8]; // see RULE5
            end
            default: begin
                cmp_hit = 1'b0;
            end
        endcase
    end

    // Next values of the sequencer
    always_comb begin
        nxt_q = q_ff + 2'h1;
        nxt_state = state_ff;
        nxt_kind = kind_ff;
        nxt_f = f_ff;
        nxt_abit = abit_ff;
        nxt_skip = skip_ff;
        nxt_two = two_ff;
        nxt_taken = 1'b0;
        case (q_ff)
            `CSB_Q1: begin
                nxt_skip = 1'b0;
                if (state_ff == csb_pkg::CSB_EXEC) begin
                    nxt_kind = decode_op(i_opcode);
                    nxt_f = i_opcode[7:0];
                    nxt_abit = i_opcode[`CSB_ABIT];
                end else begin
                    // Fetched word is dropped unexecuted
                    nxt_kind = csb_pkg::CSB_OP_NONE; // see RULE6
                end
            end
            `CSB_Q3: begin
                nxt_skip = cmp_hit;
                // Only an executed cycle's Q3 may set the length; a
                // discarded cycle must not reload it mid-skip
                if (state_ff == csb_pkg::CSB_EXEC) begin
                    nxt_two = i_next_two_word; // see RULE8
                end
            end
            `CSB_Q4: begin
                case (state_ff)
                    csb_pkg::CSB_EXEC: begin
                        if (skip_ff) begin
                            nxt_state = csb_pkg::CSB_SKIP1; // see RULE7
                            nxt_taken = 1'b1;
                        end
                    end
                    csb_pkg::CSB_SKIP1: begin
                        // Second word costs one more empty cycle
                        nxt_state = two_ff ? csb_pkg::CSB_SKIP2
                                           : csb_pkg::CSB_EXEC; // see RULE8
                    end
                    default: begin
                        nxt_state = csb_pkg::CSB_EXEC;
                    end
                endcase
            end
            default: begin
            end
        endcase
        nxt_nop = (nxt_state != csb_pkg::CSB_EXEC);
    end

    // Sequencer registers
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            q_ff <= `CSB_Q1;
            state_ff <= csb_pkg::CSB_EXEC;
            kind_ff <= csb_pkg::CSB_OP_NONE;
            f_ff <= '0;
            abit_ff <= 1'b0;
            skip_ff <= 1'b0;
            two_ff <= 1'b0;
            nop_ff <= 1'b0;
            taken_ff <= 1'b0;
        end else begin
            q_ff <= nxt_q;
            state_ff <= nxt_state;
            kind_ff <= nxt_kind;
            f_ff <= nxt_f;
            abit_ff <= nxt_abit;
            skip_ff <= nxt_skip;
            two_ff <= nxt_two;
            nop_ff <= nxt_nop;
            taken_ff <= nxt_taken;
        end
    end

    // Next values of the datapath; strobes last one quarter
    always_comb begin
        nxt_addr = addr_ff;
        nxt_rd = 1'b0;
        nxt_wdata = wdata_ff;
        nxt_we = 1'b0;
        nxt_carry = carry_ff;
        nxt_cwe = 1'b0;
        // Operand read during Q3
        if (q_ff == `CSB_Q2 && is_cmp(kind_ff)) begin
            nxt_addr = {bank_of(abit_ff, f_ff, i_bank_select_register),
                        f_ff};
            nxt_rd = 1'b1;
        end
        // Compares raise no write strobe: status stays as it was
        if (q_ff == `CSB_Q3 && kind_ff == csb_pkg::CSB_OP_DAW) begin
            nxt_wdata = bif.result; // see RULE12
            nxt_we = 1'b1;
            nxt_carry = bif.carry_out; // see RULE13
            nxt_cwe = 1'b1;
        end
    end

    // Datapath registers
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            addr_ff <= '0;
            rd_ff <= 1'b0;
            wdata_ff <= '0;
            we_ff <= 1'b0;
            carry_ff <= 1'b0;
            cwe_ff <= 1'b0;
        end else begin
            addr_ff <= nxt_addr;
            rd_ff <= nxt_rd;
            wdata_ff <= nxt_wdata;
            we_ff <= nxt_we;
            carry_ff <= nxt_carry;
            cwe_ff <= nxt_cwe;
        end
    end

    // Outputs, all straight from flip-flops
    assign o_mem_addr = addr_ff;
    assign o_mem_rd = rd_ff;
    assign o_working_register_data = wdata_ff;
    assign o_working_register_we = we_ff;
    assign o_carry = carry_ff;
    assign o_carry_we = cwe_ff;
    assign o_q_phase = q_ff;
    assign o_skip_nop = nop_ff;
    assign o_skip_taken = taken_ff;

    // Checks
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_resetn);

    logic [3:0] w_lo; // Low nibble of working register
    assign w_lo = i_working_register[3:0];

    sequence s_nop_one;
        o_skip_nop [*4] ##1 !o_skip_nop;
    endsequence
    sequence s_nop_two;
        o_skip_nop [*8] ##1 !o_skip_nop;
    endsequence

    a_decode_greater: assert property ( // see RULE1
        q_ff == `CSB_Q1 && state_ff == csb_pkg::CSB_EXEC &&
        (i_opcode & `CSB_CMP_MASK) == `CSB_OP_CMP_GT
        |=> kind_ff == csb_pkg::CSB_OP_GT)
        else $error("greater compare not decoded");
    a_decode_less: assert property ( // see RULE2
        q_ff == `CSB_Q1 && state_ff == csb_pkg::CSB_EXEC &&
        (i_opcode & `CSB_CMP_MASK) == `CSB_OP_CMP_LT
        |=> kind_ff == csb_pkg::CSB_OP_LT)
        else $error("less compare not decoded");
    a_decode_adjust: assert property ( // see RULE14
        q_ff == `CSB_Q1 && state_ff == csb_pkg::CSB_EXEC &&
        i_opcode == `CSB_OP_DAW |=> kind_ff == csb_pkg::CSB_OP_DAW)
        else $error("decimal adjust not decoded");
    a_cmp_no_write: assert property ( // see RULE3
        is_cmp(kind_ff) |-> ##1 !o_working_register_we && !o_carry_we)
        else $error("compare wrote a register or flag");
    a_greater_skip: assert property ( // see RULE4
        q_ff == `CSB_Q3 && kind_ff == csb_pkg::CSB_OP_GT
        |=> skip_ff == $past(i_mem_rdata > i_working_register))
        else $error("greater skip decision wrong");
    a_less_skip: assert property ( // see RULE5
        q_ff == `CSB_Q3 && kind_ff == csb_pkg::CSB_OP_LT
        |=> skip_ff == $past(i_mem_rdata < i_working_register))
        else $error("less skip decision wrong");
    a_nop_quiet: assert property ( // see RULE6
        o_skip_nop |-> ##1 !o_working_register_we && !o_carry_we &&
        !o_mem_rd)
        else $error("discarded cycle had side effects");
    a_skip_one: assert property ( // see RULE7
        $rose(o_skip_nop) && !two_ff |-> s_nop_one)
        else $error("single skip length wrong");
    a_skip_two: assert property ( // see RULE8
        $rose(o_skip_nop) && two_ff |-> s_nop_two)
        else $error("double skip length wrong");
    a_bank_access: assert property ( // see RULE9
        q_ff == `CSB_Q2 && is_cmp(kind_ff) && !abit_ff
        |=> o_mem_addr[BANK_W+7:8] ==
            (f_ff[`CSB_ACC_SPLIT] ? {BANK_W{1'b1}} : '0))
        else $error("access bank not used");
    a_bank_select: assert property ( // see RULE10
        q_ff == `CSB_Q2 && is_cmp(kind_ff) && abit_ff
        |=> o_mem_addr[BANK_W+7:8] == $past(i_bank_select_register))
        else $error("bank select register not used");
    a_adjust_low: assert property ( // see RULE11
        q_ff == `CSB_Q3 && kind_ff == csb_pkg::CSB_OP_DAW &&
        !(w_lo > `CSB_BCD_LIMIT) && !i_digit_carry_flag
        |=> o_working_register_we &&
            o_working_register_data[3:0] == $past(w_lo))
        else $error("low nibble changed without cause");
    a_adjust_carry: assert property ( // see RULE13
        q_ff == `CSB_Q3 && kind_ff == csb_pkg::CSB_OP_DAW && i_carry
        |=> o_carry_we && o_carry)
        else $error("carry lost by decimal adjust");

endmodule // csb_core

// ---- tb/compare_skip_and_bcd_adjust_tb.sv ----
// Purpose: Self-checking bench for the compare-skip and BCD adjust unit
// Assumes: Inputs change at the falling edge; outputs settled there too
// Notes: Integer model predicts every result; random part seeded with 19
`timescale 1ns/1ps
module compare_skip_and_bcd_adjust_tb;
    // Stimulus towards the core
    logic i_mclk = 1'b0;
    logic i_resetn = 1'b0;
    logic [15:0] i_opcode = 16'h0000;
    logic i_next_two_word = 1'b0;
    logic [7:0] i_working_register = 8'h00;
    logic [3:0] i_bank_select_register = 4'h0;
    logic i_carry = 1'b0;
    logic i_digit_carry_flag = 1'b0;
    logic [7:0] i_mem_rdata = 8'h00;
    // Observed outputs
    logic [11:0] o_mem_addr;
    logic o_mem_rd;
    logic [7:0] o_working_register_data;
    logic o_working_register_we;
    logic o_carry;
    logic o_carry_we;
    logic [1:0] o_q_phase;
    logic o_skip_nop;
    logic o_skip_taken;
    // Bookkeeping
    int n_fail = 0;
    int samples_checked = 0;
    int seed = 19;
    int cycles = 0;
    // Table of adjust vectors, packed as {carry, digit carry, value}
    logic [9:0] daw_tab [8] = '{10'h0a5, 10'h0ce, 10'h099, 10'h09a,
                                10'h112, 10'h212, 10'h0ff, 10'h300};

    csb_core #(.BANK_W(4)) u_csb_core (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_opcode(i_opcode),
        .i_next_two_word(i_next_two_word),
        .i_working_register(i_working_register),
        .i_bank_select_register(i_bank_select_register),
        .i_carry(i_carry),
        .i_digit_carry_flag(i_digit_carry_flag),
        .i_mem_rdata(i_mem_rdata),
        .o_mem_addr(o_mem_addr),
        .o_mem_rd(o_mem_rd),
        .o_working_register_data(o_working_register_data),
        .o_working_register_we(o_working_register_we),
        .o_carry(o_carry),
        .o_carry_we(o_carry_we),
        .o_q_phase(o_q_phase),
        .o_skip_nop(o_skip_nop),
        .o_skip_taken(o_skip_taken)
    );

    // 100 MHz clock
    always #5 i_mclk = ~i_mclk;

    // Hang guard; a real run needs well under 2000 clocks
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            summarize();
        end
    end

    // Counts and verdict, then stop
    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // One comparison, case equality so unknowns fail
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Issue one instruction cycle and check Q3, Q4 and the next Q1 against the model
    task automatic exec(input logic [15:0] op, input logic [7:0] w,
                        input logic [3:0] bank_select_register, input logic [7:0] rd,
                        input logic c, input logic dc, input logic n2);
        int s;
        int nclk;
        int guard;
        logic cmp;
        logic skip;
        logic decimal_adjust_working;
        logic cy;
        logic [11:0] addr;
        guard = 0;
        // Wait for a Q1 that is not a discarded cycle
        while (!(o_q_phase === 2'h0 && o_skip_nop === 1'b0) && guard < 50) begin
            @(negedge i_mclk);
            guard++;
        end
        // Model of decode, compare and adjust
        cmp = (op[15:9] == 7'h32) || (op[15:9] == 7'h30);
        decimal_adjust_working = (op == 16'h0007);
        skip = cmp && (op[10] ? (rd > w) : (rd < w));
        // Access bank splits at address bit 7
        addr = op[8] ? {bank_select_register, op[7:0]} : {{4{op[7]}}, op[7:0]};
        s = w;
        if (w[3:0] > 4'h9 || dc) s += 6;
        if (((s >> 4) & 15) > 9 || c || s > 255) s += 'h60;
        cy = c || (s > 255);
        // Drive the whole instruction; all but the opcode held for the cycle
        i_opcode = op;
        i_working_register = w;
        i_bank_select_register = bank_select_register;
        i_mem_rdata = rd;
        i_carry = c;
        i_digit_carry_flag = dc;
        i_next_two_word = n2;
        @(negedge i_mclk);
        // Opcode is sampled once only; junk here must be ignored
        i_opcode = 16'($random(seed));
        @(negedge i_mclk);
        chk(12'(o_mem_rd), 12'(cmp));
        if (cmp) chk(o_mem_addr, addr);
        @(negedge i_mclk);
        chk({10'h000, o_carry_we, o_working_register_we}, {10'h000, decimal_adjust_working, decimal_adjust_working});
        if (decimal_adjust_working) chk({3'h0, o_carry, o_working_register_data}, {3'h0, cy, s[7:0]});
        @(negedge i_mclk);
        chk({10'h000, o_skip_nop, o_skip_taken}, {10'h000, skip, skip});
        chk(12'(o_q_phase), 12'h000);
        // Discarded cycles: an adjust opcode offered here must do nothing
        nclk = 0;
        while (o_skip_nop === 1'b1 && nclk < 12) begin
            nclk++;
            i_opcode = 16'h0007;
            // Skip length was fixed by the compare; later levels are moot
            i_next_two_word = 1'b0;
            i_working_register = 8'($random(seed));
            @(negedge i_mclk);
            chk({9'h000, o_mem_rd, o_working_register_we, o_carry_we}, 12'h000);
        end
        i_opcode = 16'h0000;
        chk(12'(nclk), skip ? (n2 ? 12'h008 : 12'h004) : 12'h000);
    endtask

    // Main sequence
    initial begin
        logic [7:0] w;
        logic [7:0] f;
        logic [31:0] r;
        repeat (5) @(negedge i_mclk);
        i_resetn = 1'b1;
        // Adjust vectors, including carry-in and overflow past bit 7
        foreach (daw_tab[i]) begin
            exec(16'h0007, daw_tab[i][7:0], 4'h5, 8'h00, daw_tab[i][9], daw_tab[i][8], 1'b0);
        end
        // Both compares, both access modes, byte one below, equal, one above
        for (int k = 0; k < 2; k++) begin
            for (int a = 0; a < 2; a++) begin
                for (int rel = -1; rel < 2; rel++) begin
                    for (int n = 0; n < 2; n++) begin
                        f = 8'($random(seed));
                        w = 8'h80;
                        exec({(k == 0) ? 7'h32 : 7'h30, 1'(a), f}, w, 4'ha, 8'(w + rel), 1'b0, 1'b1, 1'(n));
                    end
                end
            end
        end
        // Neighbouring opcodes that this unit must leave alone
        exec(16'h6200, 8'h10, 4'h3, 8'h10, 1'b0, 1'b0, 1'b0);
        exec(16'h6600, 8'h10, 4'h3, 8'h20, 1'b0, 1'b0, 1'b0);
        exec(16'h0006, 8'h9a, 4'h3, 8'h00, 1'b0, 1'b0, 1'b0);
        exec(16'h0107, 8'h9a, 4'h3, 8'h00, 1'b0, 1'b0, 1'b0);
        // Extremes of the unsigned range
        exec(16'h64ff, 8'h00, 4'hf, 8'hff, 1'b0, 1'b0, 1'b1);
        exec(16'h6000, 8'hff, 4'h0, 8'h00, 1'b1, 1'b1, 1'b0);
        // Random mix, back to back
        repeat (80) begin
            r = $random(seed);
            case (r[1:0])
                2'h0: exec({7'h32, r[10:2]}, 8'($random(seed)), r[14:11], 8'($random(seed)), r[15], r[16], r[17]);
                2'h1: exec({7'h30, r[10:2]}, 8'($random(seed)), r[14:11], 8'($random(seed)), r[15], r[16], r[17]);
                2'h2: exec(16'h0007, 8'($random(seed)), r[14:11], 8'h00, r[15], r[16], 1'b0);
                default: exec(16'($random(seed)), r[9:2], r[14:11], r[25:18], r[15], r[16], r[17]);
            endcase
        end
        summarize();
    end
endmodule // compare_skip_and_bcd_adjust_tb
